// ==== include/recloser_pkg.sv ====
/*
 shared constants and types for the auto-reclose sequencer:
 timing figures, tick derivation, state encoding and carrier structs.
 assumes a 20 mhz system clock and a settings port driven by software.
*/
package recloser_pkg;

   // system clock rate and derived one-millisecond tick
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int TICK_W = 15;

   // millisecond timer width: covers 120 s dead time and more
   localparam int MS_W = 20;

   // default timing figures in milliseconds
   localparam logic [MS_W-1:0] DEF_START_MS = 20'd500;
   localparam logic [MS_W-1:0] DEF_DEAD1_MS = 20'd200;
   localparam logic [MS_W-1:0] DEF_DEAD2_MS = 20'd120000;
   localparam logic [MS_W-1:0] DEF_ARC_MS = 20'd200;
   localparam logic [MS_W-1:0] DEF_RECLAIM_MS = 20'd10000;
   localparam logic [MS_W-1:0] DEF_GLOBAL_MS = 20'd10000;

   // register map of the plain settings port
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] A_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] A_STATUS = 4'h1;
   localparam logic [ADDR_W-1:0] A_START1 = 4'h2;
   localparam logic [ADDR_W-1:0] A_DEAD1 = 4'h3;
   localparam logic [ADDR_W-1:0] A_DEAD2 = 4'h4;
   localparam logic [ADDR_W-1:0] A_ARC1 = 4'h5;
   localparam logic [ADDR_W-1:0] A_ARC2 = 4'h6;
   localparam logic [ADDR_W-1:0] A_RECL1 = 4'h7;
   localparam logic [ADDR_W-1:0] A_RECL2 = 4'h8;
   localparam logic [ADDR_W-1:0] A_GLOBAL = 4'h9;

   // control register bit positions
   localparam int C_SHOT2_EN = 0;
   localparam int C_RECUR_LOCK = 1;
   localparam int C_SKIP_GLOBAL = 2;
   localparam int C_MAN_RESET = 3;
   localparam logic [3:0] CTRL_RST = 4'h3;

   // sequencer states, gray along the listed order
   typedef enum logic [3:0] {
      ST_READY = 4'h0,
      ST_START = 4'h1,
      ST_OPEN = 4'h3,
      ST_DEAD = 4'h2,
      ST_CLOSE = 4'h6,
      ST_RECLAIM = 4'h7,
      ST_GLOBAL = 4'h5,
      ST_LOCK = 4'h4
   } seq_state_t;

   // status flags grouped for the status register
   typedef struct packed {
      logic lockout;
      logic global_rec;
      logic second_att;
      logic first_att;
      logic req_pend;
      logic active;
   } seq_flags_t;

   // breaker command pair
   typedef struct packed {
      logic open;
      logic close;
   } brk_cmd_t;

endpackage

// ==== rtl/ms_timer.sv ====
/*
 ms_timer: millisecond up-counter with run, clear and done compare.
 assumes a one-cycle tick pulse on the same clock; a zero limit is done
 at once, so zero settings bypass the timer.
*/
`timescale 1ns/1ps
`default_nettype none
module ms_timer
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // control
   input wire logic i_tick,
   input wire logic i_run,
   input wire logic i_clear,
   input wire logic [recloser_pkg::MS_W-1:0] i_limit,
   // result
   output logic o_done
);
   logic [recloser_pkg::MS_W-1:0] cnt_ff;
   logic [recloser_pkg::MS_W-1:0] nxt_cnt;

   // count holds while not running, so arcing time accumulates
   assign nxt_cnt = i_clear ? '0 :
      (i_run && i_tick && !o_done) ? cnt_ff + 1'b1 : cnt_ff;
   assign o_done = (cnt_ff >= i_limit);

   // counter register
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         cnt_ff <= '0;
      else
         cnt_ff <= nxt_cnt;
   end
endmodule
`default_nettype wire

// ==== rtl/autoreclose_seq.sv ====
/*
 autoreclose_seq: two-shot auto-reclose sequencer started by the pick-up
 of an overcurrent stage; drives breaker open/close via object control.
 assumes pick-up, closed indication and manual-operation inputs are
 asynchronous pins; settings come over a plain register port.
*/
`timescale 1ns/1ps
`default_nettype none
module autoreclose_seq
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // stage and breaker pins
   input wire logic i_pickup,
   input wire logic i_brk_closed,
   input wire logic i_manual_op,
   // register port
   input wire logic [recloser_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // breaker commands and flags
   output recloser_pkg::brk_cmd_t o_cmd,
   output recloser_pkg::seq_flags_t o_flags
);
   localparam int MW = recloser_pkg::MS_W;

   // two-flop synchronisers for the pins
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   wire pickup = sync2_ff[0];
   wire closed = sync2_ff[1];
   wire manual = sync2_ff[2];

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= {i_manual_op, i_brk_closed, i_pickup};
         sync2_ff <= sync1_ff;
      end
   end

   // settings registers
   logic [3:0] ctrl_ff;
   logic [MW-1:0] start1_ff, dead1_ff, dead2_ff, arc1_ff, arc2_ff;
   logic [MW-1:0] recl1_ff, recl2_ff, glob_ff;
   logic [31:0] rdata_ff;

   wire shot2_en = ctrl_ff[recloser_pkg::C_SHOT2_EN];
   wire recur_lock = ctrl_ff[recloser_pkg::C_RECUR_LOCK];
   wire skip_glob = ctrl_ff[recloser_pkg::C_SKIP_GLOBAL];
   wire wr_ctrl = i_wr && (i_addr == recloser_pkg::A_CTRL);
   wire man_reset = wr_ctrl && i_wdata[recloser_pkg::C_MAN_RESET];

   // register writes; manual reset bit is a self-clearing pulse
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ctrl_ff <= recloser_pkg::CTRL_RST;
         start1_ff <= recloser_pkg::DEF_START_MS;
         dead1_ff <= recloser_pkg::DEF_DEAD1_MS;
         dead2_ff <= recloser_pkg::DEF_DEAD2_MS;
         arc1_ff <= recloser_pkg::DEF_ARC_MS;
         arc2_ff <= recloser_pkg::DEF_ARC_MS;
         recl1_ff <= recloser_pkg::DEF_RECLAIM_MS;
         recl2_ff <= recloser_pkg::DEF_RECLAIM_MS;
         glob_ff <= recloser_pkg::DEF_GLOBAL_MS;
      end
      else if (i_wr)
      begin
         case (i_addr)
            recloser_pkg::A_CTRL: ctrl_ff <= {1'b0, i_wdata[2:0]};
            recloser_pkg::A_START1: start1_ff <= i_wdata[MW-1:0];
            recloser_pkg::A_DEAD1: dead1_ff <= i_wdata[MW-1:0];
            recloser_pkg::A_DEAD2: dead2_ff <= i_wdata[MW-1:0];
            recloser_pkg::A_ARC1: arc1_ff <= i_wdata[MW-1:0];
            recloser_pkg::A_ARC2: arc2_ff <= i_wdata[MW-1:0];
            recloser_pkg::A_RECL1: recl1_ff <= i_wdata[MW-1:0];
            recloser_pkg::A_RECL2: recl2_ff <= i_wdata[MW-1:0];
            recloser_pkg::A_GLOBAL: glob_ff <= i_wdata[MW-1:0];
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // common 1 ms tick
   logic [recloser_pkg::TICK_W-1:0] tick_cnt_ff;
   wire tick = (tick_cnt_ff ==
      recloser_pkg::TICK_W'(recloser_pkg::TICK_CYCLES - 1));

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         tick_cnt_ff <= '0;
      else
         tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
   end

   // sequencer state and flags
   recloser_pkg::seq_state_t state_ff, nxt_state;
   logic shot2_ff, nxt_shot2;
   logic lock_wait_ff, nxt_lock_wait;
   recloser_pkg::seq_flags_t flags_ff, nxt_flags;
   recloser_pkg::brk_cmd_t cmd_ff, nxt_cmd;

   // timers, loaded from the settings of the active shot
   wire [MW-1:0] dead_lim = shot2_ff ? dead2_ff : dead1_ff;
   wire [MW-1:0] arc_lim = shot2_ff ? arc2_ff : arc1_ff;
   wire [MW-1:0] recl_lim = shot2_ff ? recl2_ff : recl1_ff;
   wire [MW-1:0] main_lim = (state_ff == recloser_pkg::ST_START) ? start1_ff :
      (state_ff == recloser_pkg::ST_DEAD) ? dead_lim :
      (state_ff == recloser_pkg::ST_RECLAIM) ? recl_lim : glob_ff;
   wire main_run = (state_ff == recloser_pkg::ST_START) ||
      (state_ff == recloser_pkg::ST_DEAD) ||
      (state_ff == recloser_pkg::ST_RECLAIM) ||
      (state_ff == recloser_pkg::ST_GLOBAL);
   wire state_chg = (nxt_state != state_ff);
   wire arc_run = (state_ff == recloser_pkg::ST_RECLAIM) && pickup;
   // arcing count clears on every state change, so each reclaim phase starts from zero
   wire arc_clr = state_chg;
   wire main_done;
   wire arc_done;

   ms_timer u_main
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_tick(tick),
      .i_run(main_run),
      .i_clear(state_chg),
      .i_limit(main_lim),
      .o_done(main_done)
   );

   ms_timer u_arc
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_tick(tick),
      .i_run(arc_run),
      .i_clear(arc_clr),
      .i_limit(arc_lim),
      .o_done(arc_done)
   );

   // next-state logic
   always_comb
   begin
      nxt_state = state_ff;
      nxt_shot2 = shot2_ff;
      nxt_lock_wait = lock_wait_ff;
      nxt_flags = flags_ff;
      nxt_cmd = cmd_ff;
      case (state_ff)
         recloser_pkg::ST_READY:
         begin
            if (pickup)
            begin
               nxt_flags.req_pend = 1'b1;
               nxt_flags.first_att = 1'b1;
               nxt_shot2 = 1'b0;
               nxt_state = recloser_pkg::ST_START;
            end
         end
         recloser_pkg::ST_START:
         begin
            if (!pickup)
            begin
               nxt_flags = '0;
               nxt_state = recloser_pkg::ST_READY;
            end
            else if (main_done)
            begin
               nxt_flags.active = 1'b1;
               nxt_cmd.open = 1'b1;
               nxt_state = recloser_pkg::ST_OPEN;
            end
         end
         recloser_pkg::ST_OPEN:
         begin
            if (!closed && !pickup)
            begin
               nxt_cmd.open = 1'b0;
               nxt_state = recloser_pkg::ST_DEAD;
            end
         end
         recloser_pkg::ST_DEAD:
         begin
            if (main_done)
            begin
               nxt_cmd.close = 1'b1;
               nxt_state = recloser_pkg::ST_CLOSE;
            end
         end
         recloser_pkg::ST_CLOSE:
         begin
            if (closed)
            begin
               nxt_cmd.close = 1'b0;
               nxt_state = recloser_pkg::ST_RECLAIM;
            end
         end
         recloser_pkg::ST_RECLAIM:
         begin
            // arcing runs beside reclaim and wins on the same cycle
            if (arc_done && pickup)
            begin
               if (shot2_en && !shot2_ff)
               begin
                  nxt_flags.first_att = 1'b0;
                  nxt_flags.second_att = 1'b1;
                  nxt_shot2 = 1'b1;
                  nxt_cmd.open = 1'b1;
                  nxt_state = recloser_pkg::ST_OPEN;
               end
               else
               begin
                  nxt_flags = '0;
                  nxt_flags.lockout = 1'b1;
                  nxt_cmd.open = 1'b1;
                  nxt_lock_wait = 1'b0;
                  nxt_state = recloser_pkg::ST_LOCK;
               end
            end
            else if (main_done)
            begin
               nxt_flags = '0;
               if (skip_glob)
                  nxt_state = recloser_pkg::ST_READY;
               else
               begin
                  nxt_flags.global_rec = 1'b1;
                  nxt_state = recloser_pkg::ST_GLOBAL;
               end
            end
         end
         recloser_pkg::ST_GLOBAL:
         begin
            if (pickup && recur_lock)
            begin
               nxt_flags = '0;
               nxt_flags.lockout = 1'b1;
               nxt_cmd.open = 1'b1;
               nxt_lock_wait = 1'b0;
               nxt_state = recloser_pkg::ST_LOCK;
            end
            else if (main_done)
            begin
               nxt_flags.global_rec = 1'b0;
               nxt_state = recloser_pkg::ST_READY;
            end
         end
         recloser_pkg::ST_LOCK:
         begin
            // open held only until the breaker reports open
            if (!closed)
               nxt_cmd.open = 1'b0;
            if (man_reset)
               nxt_lock_wait = 1'b1;
            // a pending open must finish first, so that after a commanded open only a
            // fresh close by the operator re-arms the sequencer
            if (lock_wait_ff && closed && !pickup && !cmd_ff.open)
            begin
               nxt_flags.lockout = 1'b0;
               nxt_lock_wait = 1'b0;
               nxt_state = recloser_pkg::ST_READY;
            end
         end
         default:
         begin
            nxt_flags = '0;
            nxt_cmd = '0;
            nxt_state = recloser_pkg::ST_READY;
         end
      endcase
      // manual breaker operation during a sequence aborts it
      if (manual && (state_ff != recloser_pkg::ST_READY) &&
          (state_ff != recloser_pkg::ST_LOCK))
      begin
         nxt_flags = '0;
         nxt_flags.lockout = 1'b1;
         nxt_cmd = '0;
         nxt_lock_wait = 1'b0;
         nxt_state = recloser_pkg::ST_LOCK;
      end
   end

   // state registers
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state_ff <= recloser_pkg::ST_READY;
         shot2_ff <= 1'b0;
         lock_wait_ff <= 1'b0;
         flags_ff <= '0;
         cmd_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         shot2_ff <= nxt_shot2;
         lock_wait_ff <= nxt_lock_wait;
         flags_ff <= nxt_flags;
         cmd_ff <= nxt_cmd;
      end
   end

   // read decode; unmapped addresses read zero
   wire [31:0] status_word = {22'h0, state_ff, flags_ff};
   wire [31:0] rd_mux =
      (i_addr == recloser_pkg::A_CTRL) ? {28'h0, ctrl_ff} :
      (i_addr == recloser_pkg::A_STATUS) ? status_word :
      (i_addr == recloser_pkg::A_START1) ? {12'h0, start1_ff} :
      (i_addr == recloser_pkg::A_DEAD1) ? {12'h0, dead1_ff} :
      (i_addr == recloser_pkg::A_DEAD2) ? {12'h0, dead2_ff} :
      (i_addr == recloser_pkg::A_ARC1) ? {12'h0, arc1_ff} :
      (i_addr == recloser_pkg::A_ARC2) ? {12'h0, arc2_ff} :
      (i_addr == recloser_pkg::A_RECL1) ? {12'h0, recl1_ff} :
      (i_addr == recloser_pkg::A_RECL2) ? {12'h0, recl2_ff} :
      (i_addr == recloser_pkg::A_GLOBAL) ? {12'h0, glob_ff} : 32'h0;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         rdata_ff <= '0;
      else
         rdata_ff <= i_rd ? rd_mux : 32'h0;
   end

   assign o_rdata = rdata_ff;
   assign o_cmd = cmd_ff;
   assign o_flags = flags_ff;
endmodule
`default_nettype wire

// ==== tb/autoreclose_seq_asserts.sv ====
/*
 port checker for autoreclose_seq.
 assumes binding to the sequencer top, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module autoreclose_seq_asserts
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // pins
   input wire logic i_pickup,
   input wire logic i_brk_closed,
   input wire logic i_manual_op,
   // register port
   input wire logic [recloser_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   // commands and flags
   input wire recloser_pkg::brk_cmd_t o_cmd,
   input wire recloser_pkg::seq_flags_t o_flags
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // a manual reset write is remembered: lock-out may end only after one
   logic man_seen_ff;
   logic nxt_man_seen;
   wire man_wr = i_wr && i_addr == recloser_pkg::A_CTRL
      && i_wdata[recloser_pkg::C_MAN_RESET];
   assign nxt_man_seen = o_flags.lockout && (man_seen_ff || man_wr);
   always_ff @(posedge i_clk)
      man_seen_ff <= i_rst ? 1'b0 : nxt_man_seen;
   a_pickup_flags: assert property (
      $rose(i_pickup) && o_flags == 6'h00 |-> ##[1:4]
      (o_flags.req_pend && o_flags.first_att))
      else $error("pick-up did not raise request flags");
   a_first_early: assert property (
      $rose(o_flags.req_pend) |-> o_flags.first_att && !o_flags.active)
      else $error("request without first attempt");
   a_active_open: assert property (
      $rose(o_flags.active) |-> o_cmd.open)
      else $error("active without open command");
   a_open_hold: assert property (
      o_cmd.open && i_pickup && $past(i_pickup) && $past(i_pickup, 2)
      && !o_flags.lockout && !i_manual_op |=> o_cmd.open)
      else $error("open dropped while picked up");
   a_close_hold: assert property (
      o_cmd.close && !i_brk_closed && !$past(i_brk_closed)
      && !$past(i_brk_closed, 2) && !i_manual_op |=> o_cmd.close)
      else $error("close dropped before breaker closed");
   a_close_drop: assert property (
      o_cmd.close && i_brk_closed |-> ##[1:4] !o_cmd.close)
      else $error("close held after breaker closed");
   a_lock_clear: assert property (
      $rose(o_flags.lockout) |-> o_flags[3:0] == 4'h0)
      else $error("flags left set in lock-out");
   a_lock_hold: assert property (
      o_flags.lockout && !man_seen_ff && !man_wr |=> o_flags.lockout)
      else $error("lock-out left without manual reset");
   a_global_clear: assert property (
      $rose(o_flags.global_rec) |-> o_flags[3:0] == 4'h0)
      else $error("flags left set in global recovery");
   a_attempt_excl: assert property (
      !(o_flags.first_att && o_flags.second_att))
      else $error("both attempts active");
   // main scenarios reached
   c_second: cover property ($rose(o_flags.second_att));
   c_lock: cover property ($rose(o_flags.lockout));
   c_global: cover property ($fell(o_flags.global_rec));
endmodule
bind autoreclose_seq autoreclose_seq_asserts chk (.i_clk(i_clk),
   .i_rst(i_rst), .i_pickup(i_pickup), .i_brk_closed(i_brk_closed),
   .i_manual_op(i_manual_op), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cmd(o_cmd),
   .o_flags(o_flags));
`default_nettype wire

// ==== tb/breaker_model.sv ====
/*
 breaker_model: breaker behind object control, with travel delay.
 assumes closing conditions always met; starts closed after reset.
*/
`timescale 1ns/1ps
`default_nettype none
module breaker_model
#(
   parameter int DLY = 6
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // commands and operator
   input wire recloser_pkg::brk_cmd_t i_cmd,
   input wire logic i_slow,
   input wire logic i_man_close,
   // indication
   output logic o_closed
);
   int cnt;
   // operator close stands for a hand close in lock-out
   wire want = o_closed ? i_cmd.open :
      (i_cmd.close || i_man_close);
   wire [31:0] lim = i_slow ? 32'(4 * DLY) : 32'(DLY);
   // contacts move only after the full travel time
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         cnt <= 0;
         o_closed <= 1'b1;
      end
      else if (!want)
         cnt <= 0;
      else if (cnt == lim)
      begin
         cnt <= 0;
         o_closed <= !o_closed;
      end
      else
         cnt <= cnt + 1;
   end
endmodule
`default_nettype wire

// ==== tb/autoreclose_seq_tb.sv ====
/*
 autoreclose_seq_tb: directed bench with breaker model.
 assumes short ms settings written over the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module autoreclose_seq_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pickup = 1'b0;
   logic man_op = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic slow = 1'b0;
   logic man_close = 1'b0;
   wire [31:0] rdata;
   recloser_pkg::brk_cmd_t cmd;
   recloser_pkg::seq_flags_t flags;
   wire closed;
   int errors = 0;
   int n_checks = 0;
   // observed bits: 8 breaker closed, 7 open, 6 close, 5:0 flags
   wire [8:0] obs = {closed, cmd, flags};
   always #25 clk = ~clk;
   autoreclose_seq dut (.i_clk(clk), .i_rst(rst), .i_pickup(pickup),
      .i_brk_closed(closed), .i_manual_op(man_op), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_cmd(cmd), .o_flags(flags));
   breaker_model #(.DLY(6)) brk (.i_clk(clk), .i_rst(rst), .i_cmd(cmd),
      .i_slow(slow), .i_man_close(man_close), .o_closed(closed));
   task automatic print_verdict();
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic ck(input bit ok, input string m);
      n_checks++;
      if (!ok)
      begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   // bounded wait for one observed bit
   task automatic wt(input int b, input logic v);
      int k;
      // look only once the design's outputs have settled after the edge
      #1;
      for (k = 0; k < 40000 && obs[b] !== v; k++)
         @(posedge clk) #1;
      if (k == 40000)
      begin
         ck(1'b0, "wait bound");
         print_verdict();
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rreg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      #1 ck(rdata === e, "read data");
   endtask
   // one shot from pick-up to the reclose; stage outlasts start time
   task automatic shot();
      @(posedge clk) pickup <= 1'b1;
      wt(7, 1'b1);
      ck(flags.active === 1'b1, "active with open");
      wt(8, 1'b0);
      repeat (4) @(posedge clk);
      #1 ck(cmd.open === 1'b1, "open held");
      @(posedge clk) pickup <= 1'b0;
      wt(6, 1'b1);
      wt(6, 1'b0);
      ck(closed === 1'b1, "breaker closed");
   endtask
   task automatic unlock();
      wreg(recloser_pkg::A_CTRL, 32'h0000000b);
      @(posedge clk) man_close <= 1'b1;
      wt(5, 1'b0);
      @(posedge clk) man_close <= 1'b0;
   endtask
   task automatic t_regs();
      rreg(recloser_pkg::A_CTRL, 32'h00000003);
      rreg(recloser_pkg::A_START1, 32'(recloser_pkg::DEF_START_MS));
      rreg(recloser_pkg::A_DEAD2, 32'(recloser_pkg::DEF_DEAD2_MS));
      rreg(4'hf, 32'h0);
      wreg(recloser_pkg::A_STATUS, 32'h000003ff);
      rreg(recloser_pkg::A_STATUS, 32'h0);
      for (int a = 2; a < 7; a++)
         wreg(4'(a), 32'h0);
      for (int a = 7; a < 10; a++)
         wreg(4'(a), 32'h1);
      rreg(recloser_pkg::A_RECL2, 32'h1);
   endtask
   task automatic t_fail();
      @(posedge clk) pickup <= 1'b1;
      wt(2, 1'b1);
      ck(flags.req_pend === 1'b1 && flags.active === 1'b0, "start");
      shot();
      @(posedge clk) slow <= 1'b1;
      shot();
      ck(flags[3:2] === 2'b10, "2nd");
      @(posedge clk) pickup <= 1'b1;
      wt(5, 1'b1);
      ck(flags[3:0] === 4'h0 && cmd.open === 1'b1, "final");
      wt(8, 1'b0);
      @(posedge clk) pickup <= 1'b0;
      @(posedge clk) pickup <= 1'b1;
      repeat (8) @(posedge clk);
      #1 ck(flags === 6'h20, "locked");
      @(posedge clk) pickup <= 1'b0;
      slow <= 1'b0;
      unlock();
   endtask
   task automatic t_recur();
      wreg(recloser_pkg::A_RECL1, 32'h0);
      shot();
      wt(4, 1'b1);
      ck(flags === 6'h10, "recovery");
      @(posedge clk) pickup <= 1'b1;
      wt(5, 1'b1);
      @(posedge clk) pickup <= 1'b0;
      unlock();
   endtask
   task automatic t_ready();
      wreg(recloser_pkg::A_CTRL, 32'h00000001);
      shot();
      wt(4, 1'b1);
      // recurrence with the lock-out option off keeps recovery timing
      @(posedge clk) pickup <= 1'b1;
      repeat (5) @(posedge clk);
      #1 ck(flags === 6'h10 && cmd === 2'b00, "recurrence kept");
      @(posedge clk) pickup <= 1'b0;
      wt(4, 1'b0);
      ck(flags === 6'h00, "ready");
   endtask
   task automatic t_skip();
      wreg(recloser_pkg::A_CTRL, 32'h00000005);
      shot();
      repeat (4) @(posedge clk);
      #1 ck(flags === 6'h00, "no recovery");
   endtask
   task automatic t_manual();
      @(posedge clk) pickup <= 1'b1;
      wt(7, 1'b1);
      @(posedge clk) man_op <= 1'b1;
      wt(5, 1'b1);
      ck(flags[3:0] === 4'h0, "manual abort");
      @(posedge clk) man_op <= 1'b0;
      pickup <= 1'b0;
      unlock();
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_fail();
      t_recur();
      t_ready();
      t_skip();
      t_manual();
      print_verdict();
   end
endmodule
`default_nettype wire
